// ===== logic/tmw_pkg.sv
// constants shared by the 8-bit timer mode logic and its compare channels
// assumes a single 40 MHz clock and a prescaled tick enable from outside
package tmw_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 25;

  // register offsets
  localparam logic [2:0] OFF_CTRL_A = 3'h0;
  localparam logic [2:0] OFF_CTRL_B = 3'h1;
  localparam logic [2:0] OFF_COUNT  = 3'h2;
  localparam logic [2:0] OFF_CMP_A  = 3'h3;
  localparam logic [2:0] OFF_CMP_B  = 3'h4;
  localparam logic [2:0] OFF_FLAGS  = 3'h5;

  // control a fields
  localparam int unsigned CA_ACT_A_LSB = 6;
  localparam int unsigned CA_ACT_B_LSB = 4;
  localparam int unsigned CA_MODE_LSB  = 0;

  // control b fields
  localparam int unsigned CB_FORCE_A = 7;
  localparam int unsigned CB_FORCE_B = 6;
  localparam int unsigned CB_MODE_HI = 3;
  localparam int unsigned CB_CLK_LSB = 0;

  // flag fields
  localparam int unsigned FL_WRAP    = 0;
  localparam int unsigned FL_MATCH_A = 1;
  localparam int unsigned FL_MATCH_B = 2;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_ACT  = 2'h0;
  localparam logic [2:0] RST_CLK  = 3'h0;

  // counter extremes and count step
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;

  // wave mode codes, plus the stopped clock source code
  localparam logic [2:0] WM_NORMAL   = 3'h0;
  localparam logic [2:0] WM_CTC      = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;
  localparam logic [2:0] CLK_STOP    = 3'h0;

  // output action codes
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // counting sequence, one-hot
  typedef enum logic [3:0] {
    TMW_SEQ_NORMAL   = 4'b0001,
    TMW_SEQ_CTC      = 4'b0010,
    TMW_SEQ_FAST_MAX = 4'b0100,
    TMW_SEQ_FAST_CMP = 4'b1000
  } tmw_seq_t;

endpackage

// ===== logic/tmw_tick_if.sv
// timing bundle from the counter core to each compare channel
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface tmw_tick_if;
  logic       tick;
  logic [7:0] count;
  logic       pwm;
  logic       at_top;
  logic       block;
  logic       mode_hi;

  modport drv
  (
    output tick,
    output count,
    output pwm,
    output at_top,
    output block,
    output mode_hi
  );

  modport chan
  (
    input tick,
    input count,
    input pwm,
    input at_top,
    input block,
    input mode_hi
  );
endinterface

// ===== logic/tmw_cmp_chan.sv
// one compare channel: buffered compare value, match flag, wave state
// assumes the counter core drives the tick bundle on the same clock
`timescale 1ns/10ps
module tmw_cmp_chan
#(
  parameter bit IS_A = 1'b1
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  tmw_tick_if.chan        tk,
  input  wire logic       wr_cmp_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [1:0] action_i,
  input  wire logic       force_i,
  input  wire logic       flag_clr_i,
  output logic [7:0]      cmp_act_o,
  output logic [7:0]      cmp_buf_o,
  output logic            flag_o,
  output logic            wave_o
);

  ////////////////////////////////////////////////////////////////////////////
  // match or force action on the stored output state, used in every mode
  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    logic r;
    r = cur;
    case (act)
      tmw_pkg::ACT_TOGGLE: r = ~cur;
      tmw_pkg::ACT_CLEAR:  r = 1'b0;
      tmw_pkg::ACT_SET:    r = 1'b1;
      default:             r = cur;
    endcase
    return r;
  endfunction

  logic [7:0] cmp_buf_q;
  logic [7:0] cmp_act_q;
  logic       flag_q;
  logic       wave_q;
  logic       wave_d;

  wire logic hit      = tk.tick && (tk.count == cmp_act_q) && !tk.block;
  wire logic bottom   = tk.tick && tk.at_top;
  wire logic tgl_ok   = IS_A && tk.mode_hi;
  wire logic frc_hit  = force_i && !tk.pwm;
  wire logic reload   = tk.pwm && bottom;

  ////////////////////////////////////////////////////////////////////////////
  // output state: bottom wins over a match so cmp = top gives a flat level
  always_comb
  begin
    wave_d = wave_q;
    if (tk.pwm)
    begin
      if (bottom && action_i == tmw_pkg::ACT_CLEAR)
        wave_d = 1'b1;
      else if (bottom && action_i == tmw_pkg::ACT_SET)
        wave_d = 1'b0;
      else if (hit && action_i == tmw_pkg::ACT_TOGGLE)
        wave_d = tgl_ok ? ~wave_q : wave_q;
      else if (hit)
        wave_d = apply_act(wave_q, action_i);
    end
    else if (hit || frc_hit)
      wave_d = apply_act(wave_q, action_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cmp_buf_q <= tmw_pkg::RST_BYTE;
      cmp_act_q <= tmw_pkg::RST_BYTE;
      flag_q    <= 1'b0;
      wave_q    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_cmp_i)
        cmp_buf_q <= wdata_i;
      // pwm reloads only at the boundary; other modes take writes at once
      if (wr_cmp_i && !tk.pwm)
        cmp_act_q <= wdata_i;
      else if (reload)
        cmp_act_q <= cmp_buf_q;
      if (hit)
        flag_q <= 1'b1;
      else if (flag_clr_i)
        flag_q <= 1'b0;
      wave_q <= wave_d;
    end
  end

  assign cmp_act_o = cmp_act_q;
  assign cmp_buf_o = cmp_buf_q;
  assign flag_o    = flag_q;
  assign wave_o    = wave_q;

endmodule

// ===== logic/tmw_timer.sv
// 8-bit timer mode logic: normal, clear-on-compare and fast pwm counting
// assumes timer_tick_i is a same-clock prescaler enable, one cycle wide,
// and the direction inputs come from port logic on the same clock
`timescale 1ns/10ps

module tmw_timer
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       timer_tick_i,
  input  wire logic       wrap_ack_i,
  input  wire logic       match_a_ack_i,
  input  wire logic       match_b_ack_i,
  input  wire logic       dir_a_i,
  input  wire logic       dir_b_i,
  output logic            wave_a_o,
  output logic            wave_a_oe_o,
  output logic            wave_b_o,
  output logic            wave_b_oe_o,
  output logic            wrap_flag_o,
  output logic            match_a_flag_o,
  output logic            match_b_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [1:0] act_a_q;
  logic [1:0] act_b_q;
  logic [1:0] mode_lo_q;
  logic       mode_hi_q;
  logic [2:0] clk_src_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       block_q;
  logic       wrap_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  tmw_pkg::tmw_seq_t seq;

  logic [7:0] cmp_a_act;
  logic [7:0] cmp_a_buf;
  logic [7:0] cmp_b_buf;
  logic       flag_a;
  logic       flag_b;
  logic       wave_a;
  logic       wave_b;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic wr_ctrl_a = wr_i && addr_i == tmw_pkg::OFF_CTRL_A;
  wire logic wr_ctrl_b = wr_i && addr_i == tmw_pkg::OFF_CTRL_B;
  wire logic wr_count  = wr_i && addr_i == tmw_pkg::OFF_COUNT;
  wire logic wr_cmp_a  = wr_i && addr_i == tmw_pkg::OFF_CMP_A;
  wire logic wr_cmp_b  = wr_i && addr_i == tmw_pkg::OFF_CMP_B;
  wire logic wr_flags  = wr_i && addr_i == tmw_pkg::OFF_FLAGS;

  wire logic force_a = wr_ctrl_b && wdata_i[tmw_pkg::CB_FORCE_A];
  wire logic force_b = wr_ctrl_b && wdata_i[tmw_pkg::CB_FORCE_B];

  wire logic clr_wrap = wrap_ack_i
                     || (wr_flags && wdata_i[tmw_pkg::FL_WRAP]);
  wire logic clr_a    = match_a_ack_i
                     || (wr_flags && wdata_i[tmw_pkg::FL_MATCH_A]);
  wire logic clr_b    = match_b_ack_i
                     || (wr_flags && wdata_i[tmw_pkg::FL_MATCH_B]);

  ////////////////////////////////////////////////////////////////////////////
  // sequence decode from wave mode only; unlisted codes count as normal
  wire logic [2:0] wave_mode_sel = {mode_hi_q, mode_lo_q};

  always_comb
  begin
    case (wave_mode_sel)
      tmw_pkg::WM_CTC:      seq = tmw_pkg::TMW_SEQ_CTC;
      tmw_pkg::WM_FAST_MAX: seq = tmw_pkg::TMW_SEQ_FAST_MAX;
      tmw_pkg::WM_FAST_CMP: seq = tmw_pkg::TMW_SEQ_FAST_CMP;
      default:              seq = tmw_pkg::TMW_SEQ_NORMAL;
    endcase
  end

  wire logic is_ctc  = seq == tmw_pkg::TMW_SEQ_CTC;
  wire logic is_pwm  = seq == tmw_pkg::TMW_SEQ_FAST_MAX
                    || seq == tmw_pkg::TMW_SEQ_FAST_CMP;

  // stopped clock source masks the tick but never the bus
  wire logic tick    = timer_tick_i
                    && clk_src_q != tmw_pkg::CLK_STOP;

  wire logic [7:0] top = (seq == tmw_pkg::TMW_SEQ_FAST_CMP)
                       ? cmp_a_act : tmw_pkg::CNT_MAX;
  wire logic at_top   = count_q == top;
  // ctc clear uses raw equality so a blocked match still limits the count
  wire logic ctc_top  = count_q == cmp_a_act;
  // outside fast pwm the roll is always max to zero
  wire logic wrap_evt = tick && !wr_count
                     && (is_pwm ? at_top
                                : count_q == tmw_pkg::CNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // counter next value; a write beats clear and count
  always_comb
  begin
    count_d = count_q;
    if (wr_count)
      count_d = wdata_i;
    else if (tick && is_ctc && ctc_top)
      count_d = tmw_pkg::CNT_BOTTOM;
    else if (tick && is_pwm && at_top)
      count_d = tmw_pkg::CNT_BOTTOM;
    else if (tick)
      count_d = count_q + tmw_pkg::CNT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, data only in the cycle after the strobe
  always_comb
  begin
    case (addr_i)
      tmw_pkg::OFF_CTRL_A: rdata_d = {act_a_q, act_b_q, 2'h0, mode_lo_q};
      tmw_pkg::OFF_CTRL_B: rdata_d = {4'h0, mode_hi_q, clk_src_q};
      tmw_pkg::OFF_COUNT:  rdata_d = count_q;
      tmw_pkg::OFF_CMP_A:  rdata_d = cmp_a_buf;
      tmw_pkg::OFF_CMP_B:  rdata_d = cmp_b_buf;
      tmw_pkg::OFF_FLAGS:  rdata_d = {5'h00, flag_b, flag_a, wrap_q};
      default:             rdata_d = tmw_pkg::RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      act_a_q   <= tmw_pkg::RST_ACT;
      act_b_q   <= tmw_pkg::RST_ACT;
      mode_lo_q <= 2'h0;
      mode_hi_q <= 1'b0;
      clk_src_q <= tmw_pkg::RST_CLK;
    end
    else if (ce_i)
    begin
      if (wr_ctrl_a)
      begin
        act_a_q   <= wdata_i[tmw_pkg::CA_ACT_A_LSB +: 2];
        act_b_q   <= wdata_i[tmw_pkg::CA_ACT_B_LSB +: 2];
        mode_lo_q <= wdata_i[tmw_pkg::CA_MODE_LSB +: 2];
      end
      if (wr_ctrl_b)
      begin
        mode_hi_q <= wdata_i[tmw_pkg::CB_MODE_HI];
        clk_src_q <= wdata_i[tmw_pkg::CB_CLK_LSB +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, match blocking, wrap flag, read data
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      count_q <= tmw_pkg::RST_BYTE;
      block_q <= 1'b0;
      wrap_q  <= 1'b0;
      rdata_q <= tmw_pkg::RST_BYTE;
    end
    else if (ce_i)
    begin
      count_q <= count_d;
      // block holds through a stopped clock until the next tick uses it
      if (wr_count)
        block_q <= 1'b1;
      else if (tick)
        block_q <= 1'b0;
      // set wins over any clear in the same cycle
      if (wrap_evt)
        wrap_q <= 1'b1;
      else if (clr_wrap)
        wrap_q <= 1'b0;
      rdata_q <= rd_i ? rdata_d : tmw_pkg::RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare channels
  tmw_tick_if tk_bus ();

  assign tk_bus.tick    = tick;
  assign tk_bus.count   = count_q;
  assign tk_bus.pwm     = is_pwm;
  assign tk_bus.at_top  = at_top;
  assign tk_bus.block   = block_q;
  assign tk_bus.mode_hi = mode_hi_q;

  tmw_cmp_chan #(.IS_A(1'b1)) u_chan_a
  (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .tk         (tk_bus),
    .wr_cmp_i   (wr_cmp_a),
    .wdata_i    (wdata_i),
    .action_i   (act_a_q),
    .force_i    (force_a),
    .flag_clr_i (clr_a),
    .cmp_act_o  (cmp_a_act),
    .cmp_buf_o  (cmp_a_buf),
    .flag_o     (flag_a),
    .wave_o     (wave_a)
  );

  tmw_cmp_chan #(.IS_A(1'b0)) u_chan_b
  (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .tk         (tk_bus),
    .wr_cmp_i   (wr_cmp_b),
    .wdata_i    (wdata_i),
    .action_i   (act_b_q),
    .force_i    (force_b),
    .flag_clr_i (clr_b),
    .cmp_act_o  (),
    .cmp_buf_o  (cmp_b_buf),
    .flag_o     (flag_b),
    .wave_o     (wave_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin side: state always held, driven only when overridden and output
  assign wave_a_o       = wave_a;
  assign wave_b_o       = wave_b;
  assign wave_a_oe_o    = dir_a_i && act_a_q != tmw_pkg::ACT_NONE;
  assign wave_b_oe_o    = dir_b_i && act_b_q != tmw_pkg::ACT_NONE;
  assign wrap_flag_o    = wrap_q;
  assign match_a_flag_o = flag_a;
  assign match_b_flag_o = flag_b;
  assign rdata_o        = rdata_q;

endmodule

// ===== bench/tmw_timer_sva.sv
// assertion checker for the 8-bit timer mode logic
// assumes it is bound to tmw_timer and sees only its ports
`timescale 1ns/10ps
module tmw_timer_sva
(
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       ce_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       timer_tick_i,
  input wire logic       wrap_ack_i,
  input wire logic       match_a_ack_i,
  input wire logic       dir_a_i,
  input wire logic       dir_b_i,
  input wire logic       wave_a_o,
  input wire logic       wave_a_oe_o,
  input wire logic       wave_b_oe_o,
  input wire logic       wrap_flag_o,
  input wire logic       match_a_flag_o
);
  // shadow of the control bytes; writes and reset are both gated by ce here
  logic [7:0] ctl_a_q;
  logic [7:0] ctl_b_q;
  wire logic       w_ctla = ce_i && wr_i && addr_i == tmw_pkg::OFF_CTRL_A;
  wire logic       w_ctlb = wr_i && addr_i == tmw_pkg::OFF_CTRL_B;
  wire logic       w_flg  = wr_i && addr_i == tmw_pkg::OFF_FLAGS;
  wire logic [2:0] mode   = {ctl_b_q[3], ctl_a_q[1:0]};
  wire logic       clk_on = ctl_b_q[2:0] != tmw_pkg::CLK_STOP;
  wire logic       non_pwm = mode == tmw_pkg::WM_NORMAL
                          || mode == tmw_pkg::WM_CTC;

  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && !rst_n_i)
    begin
      ctl_a_q <= 8'h00;
      ctl_b_q <= 8'h00;
    end
    else if (w_ctla)
      ctl_a_q <= wdata_i;
    else if (ce_i && w_ctlb)
      ctl_b_q <= wdata_i;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  //////////////////////////////////////////////////////////////////////////
  a_oe_a_dir: assert property (
    wave_a_oe_o == (dir_a_i && ctl_a_q[7:6] != tmw_pkg::ACT_NONE))
    else $error("pin a enable wrong");
  a_oe_b_dir: assert property (
    wave_b_oe_o == (dir_b_i && ctl_a_q[5:4] != tmw_pkg::ACT_NONE))
    else $error("pin b enable wrong");
  a_wrap_holds: assert property (
    ce_i && wrap_flag_o && !wrap_ack_i && !(w_flg && wdata_i[0])
    |=> wrap_flag_o) else $error("wrap flag lost");
  a_wrap_ack: assert property (
    ce_i && wrap_ack_i && !timer_tick_i |=> !wrap_flag_o)
    else $error("wrap flag not cleared");
  a_match_holds: assert property (
    ce_i && match_a_flag_o && !match_a_ack_i && !(w_flg && wdata_i[1])
    |=> match_a_flag_o) else $error("match a flag lost");
  a_wrap_by_tick: assert property (
    $rose(wrap_flag_o) |-> $past(timer_tick_i) && $past(clk_on))
    else $error("wrap flag without tick");
  a_force_toggle: assert property (
    ce_i && w_ctlb && wdata_i[7] && !wdata_i[3] && !timer_tick_i
    && non_pwm && ctl_a_q[7:6] == tmw_pkg::ACT_TOGGLE
    |=> wave_a_o != $past(wave_a_o)) else $error("force did not toggle");
  a_wave_quiet: assert property (
    ce_i && !timer_tick_i && !w_ctlb |=> $stable(wave_a_o))
    else $error("wave a moved without event");
endmodule

bind tmw_timer tmw_timer_sva u_sva
(
  .sys_clk_i,
  .rst_n_i,
  .ce_i,
  .addr_i,
  .wdata_i,
  .wr_i,
  .timer_tick_i,
  .wrap_ack_i,
  .match_a_ack_i,
  .dir_a_i,
  .dir_b_i,
  .wave_a_o,
  .wave_a_oe_o,
  .wave_b_oe_o,
  .wrap_flag_o,
  .match_a_flag_o
);

// ===== bench/tmw_pin_model.sv
// port pin with a pull-up, driven by the compare output when enabled
// assumes enable high means the block drives the pin
`timescale 1ns/10ps
module tmw_pin_model
#(
  parameter logic PULL = 1'b1
)
(
  input  wire logic drv_i,
  input  wire logic oe_i,
  output logic      pin_o
);
  // released pin falls back to the pull level, never the last value
  assign pin_o = oe_i ? drv_i : PULL;
endmodule

// ===== bench/tmw_timer_tb.sv
// self-checking bench for the 8-bit timer mode logic
// assumes tmw_timer, its checker and the pin model are compiled first
`timescale 1ns/10ps
module tmw_timer_tb;
  logic       clk;
  logic       rst_n;
  logic       ce;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       tick;
  logic       ack_w;
  logic       ack_a;
  logic       dir_a;
  logic       wa;
  logic       wa_oe;
  logic       wb;
  logic       wb_oe;
  logic       f_wrap;
  logic       f_a;
  logic       f_b;
  logic       pin_a;
  logic       pin_b;
  int         error_cnt = 0;
  int         n_checks = 0;

  tmw_timer uut
  (
    .sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .timer_tick_i(tick), .wrap_ack_i(ack_w), .match_a_ack_i(ack_a),
    .match_b_ack_i(1'b0), .dir_a_i(dir_a), .dir_b_i(1'b0),
    .wave_a_o(wa), .wave_a_oe_o(wa_oe), .wave_b_o(wb),
    .wave_b_oe_o(wb_oe), .wrap_flag_o(f_wrap), .match_a_flag_o(f_a),
    .match_b_flag_o(f_b)
  );
  tmw_pin_model pa (.drv_i(wa), .oe_i(wa_oe), .pin_o(pin_a));
  tmw_pin_model pb (.drv_i(wb), .oe_i(wb_oe), .pin_o(pin_b));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("reg read", rdata, e);
  endtask

  task automatic tk(input int n);
    @(posedge clk);
    tick <= 1'b1;
    repeat (n) @(posedge clk);
    tick <= 1'b0;
    #1;
  endtask

  task automatic ack(input bit on_a);
    @(posedge clk);
    ack_w <= !on_a;
    ack_a <= on_a;
    @(posedge clk);
    ack_w <= 1'b0;
    ack_a <= 1'b0;
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    tick = 1'b0;
    ack_w = 1'b0;
    ack_a = 1'b0;
    dir_a = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd_reg(3'(i), 8'h00);
    chk("wave a", {7'h00, wa}, 8'h00);
    // normal mode, stopped then running
    wr_reg(tmw_pkg::OFF_COUNT, 8'hFD);
    tk(2);
    rd_reg(tmw_pkg::OFF_COUNT, 8'hFD);
    wr_reg(tmw_pkg::OFF_CTRL_B, 8'h01);
    tk(3);
    rd_reg(tmw_pkg::OFF_COUNT, 8'h00);
    chk("wrap", {7'h00, f_wrap}, 8'h01);
    ack(1'b0);
    chk("wrap", {7'h00, f_wrap}, 8'h00);
    // ctc with toggle on channel a
    wr_reg(tmw_pkg::OFF_CTRL_A, 8'h42);
    wr_reg(tmw_pkg::OFF_CMP_A, 8'h02);
    wr_reg(tmw_pkg::OFF_COUNT, 8'h00);
    tk(3);
    rd_reg(tmw_pkg::OFF_COUNT, 8'h00);
    chk("match a", {7'h00, f_a}, 8'h01);
    chk("wave a", {7'h00, wa}, 8'h01);
    ack(1'b1);
    chk("match a", {7'h00, f_a}, 8'h00);
    wr_reg(tmw_pkg::OFF_COUNT, 8'h10);
    tk(240);
    rd_reg(tmw_pkg::OFF_COUNT, 8'h00);
    chk("wrap", {7'h00, f_wrap}, 8'h01);
    chk("match a", {7'h00, f_a}, 8'h00);
    wr_reg(tmw_pkg::OFF_COUNT, 8'h02);
    tk(1);
    chk("match a", {7'h00, f_a}, 8'h00);
    chk("wave a", {7'h00, wa}, 8'h01);
    wr_reg(tmw_pkg::OFF_CTRL_B, 8'h81);
    #1;
    chk("wave a", {7'h00, wa}, 8'h00);
    chk("match a", {7'h00, f_a}, 8'h00);
    rd_reg(tmw_pkg::OFF_COUNT, 8'h00);
    chk("pin a", {7'h00, pin_a}, 8'h00);
    chk("pin b", {7'h00, pin_b}, 8'h01);
    // fast pwm to 0xFF: a sets on match, b clears on match
    wr_reg(tmw_pkg::OFF_CTRL_A, 8'hE3);
    wr_reg(tmw_pkg::OFF_CMP_A, 8'h80);
    wr_reg(tmw_pkg::OFF_FLAGS, 8'h07);
    wr_reg(tmw_pkg::OFF_COUNT, 8'h00);
    tk(3);
    chk("wave a", {7'h00, wa}, 8'h01);
    tk(253);
    rd_reg(tmw_pkg::OFF_COUNT, 8'h00);
    chk("wave a", {7'h00, wa}, 8'h00);
    chk("wave b", {7'h00, wb}, 8'h01);
    chk("wrap", {7'h00, f_wrap}, 8'h01);
    tk(128);
    chk("wave a", {7'h00, wa}, 8'h00);
    chk("wave b", {7'h00, wb}, 8'h00);
    chk("match b", {7'h00, f_b}, 8'h01);
    tk(1);
    chk("wave a", {7'h00, wa}, 8'h01);
    // fast pwm to compare a, toggle asked on both channels
    wr_reg(tmw_pkg::OFF_COUNT, 8'h00);
    wr_reg(tmw_pkg::OFF_CTRL_B, 8'h09);
    wr_reg(tmw_pkg::OFF_CMP_A, 8'h04);
    wr_reg(tmw_pkg::OFF_CTRL_A, 8'h53);
    wr_reg(tmw_pkg::OFF_FLAGS, 8'h07);
    tk(129);
    rd_reg(tmw_pkg::OFF_COUNT, 8'h00);
    chk("wrap", {7'h00, f_wrap}, 8'h01);
    tk(5);
    rd_reg(tmw_pkg::OFF_COUNT, 8'h00);
    chk("wave b", {7'h00, wb}, 8'h00);
    @(posedge clk);
    dir_a <= 1'b0;
    #1;
    chk("pin a", {7'h00, pin_a}, 8'h01);
    complete_run();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule
